// ---- verilog/rct_counter_tick.sv ----
// Real-time counter and tick timer with an AXI4-Lite register slave.
// Assumes the slow clock arrives as a pin much slower than ref_clk_in,
// and that sleep and halt levels come from logic on ref_clk_in.
//
// How it works
// - counter wrapping from limit to zero sets the wrap flag
// - counter equal to match value sets the match flag
// - each tick interval elapsed sets the tick flag
// - interrupt line high while enable and flag both set
// - separate enable and flag registers for counter and tick
// - counter runs in Idle, in Standby only with keep-running bit
// - tick timer runs in every sleep mode
// - counter and tick advance on slow clock edges only
// - sync status bits 3..0 show match, limit, count, main busy
// - halted without run bit stops the counter
// - halted without tick run bit forces tick output low
// - resume with tick high gives a fresh edge and extra flag
// - divider field 6:3 divides slow clock by two to its power
// - divider write takes effect two slow clock edges later
// - main control bit 0 enables counter, resets to zero
// - main control bit 7 keeps counter running in Standby
// - enable bit 1 gates the match interrupt
// - writing one clears a flag, zero leaves it
// - enable bit 0 gates the wrap interrupt
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
module rct_counter_tick
   import rct_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire rct_axi_req_t axi_req_in,
   output rct_axi_rsp_t axi_rsp_out,
   input wire logic slow_clk_in,
   input wire logic sleep_standby_in,
   input wire logic cpu_halted_in,
   output logic counter_irq_out,
   output logic tick_irq_out,
   output logic tick_level_out,
   output logic wrap_event_out,
   output logic match_event_out
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] sync;
      logic slow_lvl;
      logic aw_held;
      logic [5:0] aw_idx;
      logic w_held;
      logic [15:0] w_data;
      logic [1:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [15:0] rdata;
      logic [7:0] main_ctrl;
      logic [7:0] main_act;
      logic [NBUSY-1:0] busy;
      logic [2*NBUSY-1:0] stage;
      logic [15:0] cnt;
      logic [15:0] cnt_sh;
      logic [15:0] limit;
      logic [15:0] limit_sh;
      logic [15:0] match;
      logic [15:0] match_sh;
      logic [1:0] irq_en;
      logic [1:0] flags;
      logic [7:0] temp;
      logic run_halt;
      logic [1:0] source_clock_choice;
      logic [7:0] tick_ctrl;
      logic [7:0] tick_act;
      logic tick_en;
      logic tick_flag;
      logic tick_run_halt;
      logic [15:0] pre;
      logic tick_q;
      logic wrap_ev;
      logic match_ev;
   } rct_state_t;
   rct_state_t r_reg;
   rct_state_t r_next;
   logic settled;
   logic slow_tick;
   logic cnt_run;
   logic adv;
   logic wrap_hit;
   logic match_hit;
   logic apply_cnt;
   logic tick_gated;
   logic tick_rise;
   logic wr_go;
   logic rd_go;
   logic awready;
   logic wready;
   logic arready;
   logic [15:0] mask;
   logic [15:0] cnt_inc;
   logic [3:0] wrap_limit;
   logic [1:0] clr_f;
   logic clr_t;
   logic [NBUSY-1:0] start;
   // Byte-lane merge for the 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
      input logic [15:0] new_v, input logic [1:0] strb);
      merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
                 strb[0] ? new_v[7:0] : old_v[7:0]};
   endfunction
   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      r_next = r_reg;
      // Slow clock pin: edge counts once stages two and three agree
      r_next.sync = {r_reg.sync[1:0], slow_clk_in};
      settled = r_reg.sync[1] == r_reg.sync[2];
      if (settled) begin
         r_next.slow_lvl = r_reg.sync[2];
      end
      slow_tick = settled && r_reg.sync[2] && !r_reg.slow_lvl;
      // Shared prescaler, idle while both functions are off
      if (!(r_reg.main_act[MC_ON] || r_reg.tick_act[TK_ON])) begin
         r_next.pre = '0;
      end else if (slow_tick) begin
         r_next.pre = r_reg.pre + 16'h1;
      end
      mask = ~(16'hFFFF << r_reg.main_act[MC_DIV_LSB+:4]);
      // Counter gating by enable, standby and debug halt
      cnt_run = r_reg.main_act[MC_ON]
         && !(sleep_standby_in && !r_reg.main_act[MC_ASLEEP])
         && !(cpu_halted_in && !r_reg.run_halt);
      adv = slow_tick && cnt_run && ((r_reg.pre & mask) == mask);
      wrap_hit = adv && (r_reg.cnt == r_reg.limit);
      cnt_inc = wrap_hit ? 16'h0000 : r_reg.cnt + 16'h1;
      match_hit = adv && (cnt_inc == r_reg.match);
      if (adv) begin
         r_next.cnt = cnt_inc;
      end
      r_next.wrap_ev = wrap_hit;
      r_next.match_ev = match_hit;
      // Tick output follows one prescaler bit; sleep does not touch it
      wrap_limit = r_reg.tick_act[TK_PER_LSB+:4];
      tick_gated = r_reg.tick_act[TK_ON] && (wrap_limit != 4'h0)
         && r_reg.pre[wrap_limit]
         && !(cpu_halted_in && !r_reg.tick_run_halt);
      r_next.tick_q = tick_gated;
      tick_rise = tick_gated && !r_reg.tick_q;
      // Pending writes land after SYNC_STAGES slow edges
      apply_cnt = 1'b0;
      for (int i = 0; i < NBUSY; i++) begin
         if (r_reg.busy[i] && slow_tick) begin
            r_next.stage[2*i+:2] = r_reg.stage[2*i+:2] - 2'h1;
            if (r_reg.stage[2*i+:2] == 2'h1) begin
               r_next.busy[i] = 1'b0;
               case (i)
                  B_MAIN: r_next.main_act = r_reg.main_ctrl;
                  B_CNT: begin
                     r_next.cnt = r_reg.cnt_sh;
                     apply_cnt = 1'b1;
                  end
                  B_LIM: r_next.limit = r_reg.limit_sh;
                  B_MATCH: r_next.match = r_reg.match_sh;
                  default: r_next.tick_act = r_reg.tick_ctrl;
               endcase
            end
         end
      end
      // Write address and data are taken independently
      awready = !r_reg.aw_held && !r_reg.bvalid;
      wready = !r_reg.w_held && !r_reg.bvalid;
      if (axi_req_in.awvalid && awready) begin
         r_next.aw_held = 1'b1;
         r_next.aw_idx = axi_req_in.awaddr[7:2];
      end
      if (axi_req_in.wvalid && wready) begin
         r_next.w_held = 1'b1;
         r_next.w_data = axi_req_in.wdata[15:0];
         r_next.w_strb = axi_req_in.wstrb[1:0];
      end
      if (r_reg.bvalid && axi_req_in.bready) begin
         r_next.bvalid = 1'b0;
      end
      // Register writes; a busy write restarts its own crossing
      wr_go = r_reg.aw_held && r_reg.w_held && !r_reg.bvalid;
      start = '0;
      clr_f = 2'h0;
      clr_t = 1'b0;
      if (wr_go) begin
         r_next.aw_held = 1'b0;
         r_next.w_held = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = RESP_OKAY;
         case (r_reg.aw_idx)
            IDX_MAIN_CTRL: if (r_reg.w_strb[0]) begin
               r_next.main_ctrl = r_reg.w_data[7:0] & MAIN_CTRL_MASK;
               start[B_MAIN] = 1'b1;
            end
            IDX_IRQ_EN: if (r_reg.w_strb[0]) begin
               r_next.irq_en = r_reg.w_data[1:0];
            end
            IDX_IRQ_FLAGS: if (r_reg.w_strb[0]) begin
               clr_f = r_reg.w_data[1:0];
            end
            IDX_WIDE_LATCH: if (r_reg.w_strb[0]) begin
               r_next.temp = r_reg.w_data[7:0];
            end
            IDX_DBG_CTRL: if (r_reg.w_strb[0]) begin
               r_next.run_halt = r_reg.w_data[0];
            end
            IDX_SRC_CLK: if (r_reg.w_strb[0]) begin
               r_next.source_clock_choice = r_reg.w_data[1:0];
            end
            IDX_COUNT: if (|r_reg.w_strb) begin
               r_next.cnt_sh = merge16(r_reg.cnt_sh, r_reg.w_data,
                  r_reg.w_strb);
               start[B_CNT] = 1'b1;
            end
            IDX_LIMIT: if (|r_reg.w_strb) begin
               r_next.limit_sh = merge16(r_reg.limit_sh, r_reg.w_data,
                  r_reg.w_strb);
               start[B_LIM] = 1'b1;
            end
            IDX_MATCH: if (|r_reg.w_strb) begin
               r_next.match_sh = merge16(r_reg.match_sh, r_reg.w_data,
                  r_reg.w_strb);
               start[B_MATCH] = 1'b1;
            end
            IDX_TICK_CTRL: if (r_reg.w_strb[0]) begin
               r_next.tick_ctrl = r_reg.w_data[7:0] & TICK_CTRL_MASK;
               start[B_TICK] = 1'b1;
            end
            IDX_TICK_EN: if (r_reg.w_strb[0]) begin
               r_next.tick_en = r_reg.w_data[0];
            end
            IDX_TICK_FLAGS: if (r_reg.w_strb[0]) begin
               clr_t = r_reg.w_data[0];
            end
            IDX_TICK_DBG: if (r_reg.w_strb[0]) begin
               r_next.tick_run_halt = r_reg.w_data[0];
            end
            IDX_SYNC_STAT, IDX_TICK_STAT: ; // Read-only, write ignored
            default: r_next.bresp = RESP_SLVERR;
         endcase
      end
      for (int i = 0; i < NBUSY; i++) begin
         if (start[i]) begin
            r_next.busy[i] = 1'b1;
            r_next.stage[2*i+:2] = SYNC_STAGES;
         end
      end
      // Flags: a set in the clearing cycle wins
      r_next.flags = (r_reg.flags & ~clr_f) | {match_hit, wrap_hit};
      r_next.tick_flag = (r_reg.tick_flag & ~clr_t) | tick_rise;
      // Read channel
      arready = !r_reg.rvalid;
      rd_go = axi_req_in.arvalid && arready;
      if (r_reg.rvalid && axi_req_in.rready) begin
         r_next.rvalid = 1'b0;
      end
      if (rd_go) begin
         r_next.rvalid = 1'b1;
         r_next.rresp = RESP_OKAY;
         r_next.rdata = 16'h0000;
         case (axi_req_in.araddr[7:2])
            IDX_MAIN_CTRL: r_next.rdata[7:0] = r_reg.main_ctrl;
            IDX_SYNC_STAT: r_next.rdata[3:0] = r_reg.busy[3:0];
            IDX_IRQ_EN: r_next.rdata[1:0] = r_reg.irq_en;
            IDX_IRQ_FLAGS: r_next.rdata[1:0] = r_reg.flags;
            IDX_WIDE_LATCH: r_next.rdata[7:0] = r_reg.temp;
            IDX_DBG_CTRL: r_next.rdata[0] = r_reg.run_halt;
            IDX_SRC_CLK: r_next.rdata[1:0] = r_reg.source_clock_choice;
            IDX_COUNT: r_next.rdata = r_reg.cnt;
            IDX_LIMIT: r_next.rdata = r_reg.limit_sh;
            IDX_MATCH: r_next.rdata = r_reg.match_sh;
            IDX_TICK_CTRL: r_next.rdata[7:0] = r_reg.tick_ctrl;
            IDX_TICK_STAT: r_next.rdata[0] = r_reg.busy[B_TICK];
            IDX_TICK_EN: r_next.rdata[0] = r_reg.tick_en;
            IDX_TICK_FLAGS: r_next.rdata[0] = r_reg.tick_flag;
            IDX_TICK_DBG: r_next.rdata[0] = r_reg.tick_run_halt;
            default: r_next.rresp = RESP_SLVERR;
         endcase
      end
   end
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         r_reg <= '0;
         r_reg.main_ctrl <= MAIN_CTRL_RST;
         r_reg.main_act <= MAIN_CTRL_RST;
         r_reg.limit <= LIMIT_RST;
         r_reg.limit_sh <= LIMIT_RST;
      end else begin
         r_reg <= r_next;
      end
   end
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_comb begin
      axi_rsp_out = '0;
      axi_rsp_out.awready = awready;
      axi_rsp_out.wready = wready;
      axi_rsp_out.bvalid = r_reg.bvalid;
      axi_rsp_out.bresp = r_reg.bresp;
      axi_rsp_out.arready = arready;
      axi_rsp_out.rvalid = r_reg.rvalid;
      axi_rsp_out.rresp = r_reg.rresp;
      axi_rsp_out.rdata[15:0] = r_reg.rdata;
   end
   // Two vectors: counter wrap/match and tick
   assign counter_irq_out = |(r_reg.flags & r_reg.irq_en);
   assign tick_irq_out = r_reg.tick_flag & r_reg.tick_en;
   assign tick_level_out = r_reg.tick_q;
   assign wrap_event_out = r_reg.wrap_ev;
   assign match_event_out = r_reg.match_ev;
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!nrst_in);
   sequence tick_rise_s;
      tick_gated && !r_reg.tick_q;
   endsequence
   // A counter load in the wrap cycle wins over the wrap to zero
   wrap_flag_a: assert property (
      adv && !apply_cnt && r_reg.cnt == r_reg.limit
         |=> r_reg.flags[IRQ_WRAP] && r_reg.cnt == 16'h0000)
      else $error("wrap did not set flag");
   match_flag_a: assert property (
      $rose(r_reg.flags[IRQ_MATCH]) |-> $past(adv)
         && (r_reg.cnt == $past(r_reg.match) || $past(apply_cnt)))
      else $error("match flag without match");
   tick_flag_a: assert property (
      tick_rise_s |=> r_reg.tick_flag && r_reg.tick_q)
      else $error("tick edge lost");
   irq_hold_a: assert property (
      tick_irq_out && !wr_go |=> tick_irq_out)
      else $error("tick request dropped early");
   main_sync_a: assert property (
      $fell(r_reg.busy[B_MAIN]) |-> $past(slow_tick)
         && r_reg.main_act == $past(r_reg.main_ctrl))
      else $error("control applied off a slow edge");
   halt_stop_a: assert property (
      cpu_halted_in && !r_reg.run_halt && !apply_cnt
         |=> $stable(r_reg.cnt))
      else $error("counter moved while halted");
   tick_low_a: assert property (
      cpu_halted_in && !r_reg.tick_run_halt |=> !tick_level_out)
      else $error("tick high while halted");
   standby_a: assert property (
      sleep_standby_in && !r_reg.main_act[MC_ASLEEP] && !apply_cnt
         |=> $stable(r_reg.cnt))
      else $error("counter ran in standby");
endmodule

// ---- pkg/rct_pkg.sv ----
// Shared constants and carriers for the real-time counter with tick timer.
// Assumes a 32-bit AXI4-Lite master and byte address = 4 * register index.
package rct_pkg;
   // ----------------------------------------
   // Register indices (byte address is four times these)
   // ----------------------------------------
   localparam logic [5:0] IDX_MAIN_CTRL = 6'h00;
   localparam logic [5:0] IDX_SYNC_STAT = 6'h01;
   localparam logic [5:0] IDX_IRQ_EN = 6'h02;
   localparam logic [5:0] IDX_IRQ_FLAGS = 6'h03;
   localparam logic [5:0] IDX_WIDE_LATCH = 6'h04;
   localparam logic [5:0] IDX_DBG_CTRL = 6'h05;
   localparam logic [5:0] IDX_SRC_CLK = 6'h07;
   localparam logic [5:0] IDX_COUNT = 6'h08;
   localparam logic [5:0] IDX_LIMIT = 6'h0A;
   localparam logic [5:0] IDX_MATCH = 6'h0C;
   localparam logic [5:0] IDX_TICK_CTRL = 6'h10;
   localparam logic [5:0] IDX_TICK_STAT = 6'h11;
   localparam logic [5:0] IDX_TICK_EN = 6'h12;
   localparam logic [5:0] IDX_TICK_FLAGS = 6'h13;
   localparam logic [5:0] IDX_TICK_DBG = 6'h15;
   // ----------------------------------------
   // Field positions and writable masks
   // ----------------------------------------
   localparam int MC_ON = 0;
   localparam int MC_DIV_LSB = 3;
   localparam int MC_ASLEEP = 7;
   localparam int TK_ON = 0;
   localparam int TK_PER_LSB = 3;
   localparam int IRQ_WRAP = 0;
   localparam int IRQ_MATCH = 1;
   localparam logic [7:0] MAIN_CTRL_MASK = 8'hF9;
   localparam logic [7:0] TICK_CTRL_MASK = 8'h79;
   // Busy indices equal sync status bit positions; tick uses its own reg
   localparam int B_MAIN = 0;
   localparam int B_CNT = 1;
   localparam int B_LIM = 2;
   localparam int B_MATCH = 3;
   localparam int B_TICK = 4;
   localparam int NBUSY = 5;
   // Slow-clock edges from a write until it takes effect
   localparam logic [1:0] SYNC_STAGES = 2'h2;
   // ----------------------------------------
   // Reset values and bus answers
   // ----------------------------------------
   localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
   localparam logic [15:0] LIMIT_RST = 16'hFFFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } rct_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } rct_axi_rsp_t;
endpackage

// ---- bench/rct_counter_tick_tb.sv ----
// Self-checking bench for the counter and tick timer block.
// Assumes a free-running slow clock made here at a tenth of the bus rate.
`timescale 1ns/10ps
module rct_counter_tick_tb
   import rct_pkg::*;
;
   // ----------------------------------------
   // Stimulus, observed outputs and counters
   // ----------------------------------------
   logic ref_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic slow_clk_in = 1'b0;
   logic sleep_standby_in = 1'b0;
   logic cpu_halted_in = 1'b0;
   rct_axi_req_t req;
   rct_axi_rsp_t rsp;
   logic counter_irq;
   logic tick_irq;
   logic tick_level;
   logic wrap_ev;
   logic match_ev;
   int fails = 0;
   int cmp_count = 0;
   int slow_div = 0;
   logic [31:0] rd;
   logic [1:0] rs;

   rct_counter_tick dut (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .axi_req_in(req),
      .axi_rsp_out(rsp),
      .slow_clk_in(slow_clk_in),
      .sleep_standby_in(sleep_standby_in),
      .cpu_halted_in(cpu_halted_in),
      .counter_irq_out(counter_irq),
      .tick_irq_out(tick_irq),
      .tick_level_out(tick_level),
      .wrap_event_out(wrap_ev),
      .match_event_out(match_ev)
   );

   // Bus clock, 25 ns period
   always #12.5 ref_clk_in = ~ref_clk_in;

   // Slow clock: 5 bus cycles per phase keeps the synchronizer happy
   always_ff @(posedge ref_clk_in) begin
      if (slow_div == 4) begin
         slow_div <= 0;
         slow_clk_in <= ~slow_clk_in;
      end else begin
         slow_div <= slow_div + 1;
      end
   end

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic give_up(input string what);
      fails++;
      $display("MISMATCH %s expected answer seen timeout", what);
      stop_test();
   endtask

   // ----------------------------------------
   // Bus master; readiness sampled at the falling edge, which holds the
   // value the next rising edge sees, so no race with the design
   // ----------------------------------------
   task automatic axi_wr(input logic [5:0] idx, input logic [15:0] d,
      output logic [1:0] resp);
      logic aw_ok;
      logic w_ok;
      logic a;
      logic w;
      int n;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      n = 0;
      req.awvalid <= 1'b1;
      req.awaddr <= {idx, 2'b00};
      req.wvalid <= 1'b1;
      req.wdata <= {16'h0000, d};
      req.wstrb <= 4'h3;
      while (!(aw_ok && w_ok)) begin
         @(negedge ref_clk_in);
         a = req.awvalid && rsp.awready;
         w = req.wvalid && rsp.wready;
         n++;
         if (n > 200) give_up("write");
         @(posedge ref_clk_in);
         if (a) begin
            aw_ok = 1'b1;
            req.awvalid <= 1'b0;
         end
         if (w) begin
            w_ok = 1'b1;
            req.wvalid <= 1'b0;
         end
      end
      do begin
         @(negedge ref_clk_in);
         n++;
         if (n > 200) give_up("write response");
      end while (rsp.bvalid !== 1'b1);
      resp = rsp.bresp;
      @(posedge ref_clk_in);
   endtask

   task automatic axi_rd(input logic [5:0] idx, output logic [31:0] d,
      output logic [1:0] resp);
      int n;
      n = 0;
      req.arvalid <= 1'b1;
      req.araddr <= {idx, 2'b00};
      do begin
         @(negedge ref_clk_in);
         n++;
         if (n > 200) give_up("read address");
      end while (rsp.arready !== 1'b1);
      @(posedge ref_clk_in);
      req.arvalid <= 1'b0;
      do begin
         @(negedge ref_clk_in);
         n++;
         if (n > 200) give_up("read data");
      end while (rsp.rvalid !== 1'b1);
      d = rsp.rdata;
      resp = rsp.rresp;
      @(posedge ref_clk_in);
   endtask

   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      axi_wr(idx, d, rs);
      check("bresp", {30'h0, RESP_OKAY}, {30'h0, rs});
   endtask

   task automatic rd_chk(input string name, input logic [5:0] idx,
      input logic [31:0] exp);
      axi_rd(idx, rd, rs);
      check(name, exp, rd);
   endtask

   // Poll both status registers until no crossing is pending
   task automatic wait_idle;
      logic [31:0] t;
      int n;
      n = 0;
      do begin
         axi_rd(IDX_SYNC_STAT, rd, rs);
         axi_rd(IDX_TICK_STAT, t, rs);
         n++;
         if (n > 100) give_up("sync busy");
      end while (rd !== 32'h0 || t !== 32'h0);
   endtask

   task automatic wait_sig(ref logic s, input string what);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk_in);
         n++;
         if (n > 400) give_up(what);
      end while (s !== 1'b1);
      @(posedge ref_clk_in);
   endtask

   task automatic see(input string name, ref logic s, input logic exp);
      repeat (2) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      check(name, {31'h0, exp}, {31'h0, s});
      @(posedge ref_clk_in);
   endtask

   // Event pulse: seen high, then gone one cycle later
   task automatic pulse(ref logic s, input string name);
      wait_sig(s, name);
      @(negedge ref_clk_in);
      check(name, 32'h0, {31'h0, s});
      @(posedge ref_clk_in);
   endtask

   // Counter steps seen over a window, after the pipeline settles
   task automatic delta(input int cycles, output int dl);
      logic [31:0] c0;
      repeat (10) @(posedge ref_clk_in);
      axi_rd(IDX_COUNT, c0, rs);
      repeat (cycles) @(posedge ref_clk_in);
      axi_rd(IDX_COUNT, rd, rs);
      dl = int'(rd[15:0] - c0[15:0]);
   endtask

   task automatic moved(input logic exp_run);
      int dl;
      delta(100, dl);
      check("counter running", {31'h0, exp_run}, {31'h0, dl != 0});
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic s_reset;
      rd_chk("main control", IDX_MAIN_CTRL, 32'h0);
      rd_chk("sync status", IDX_SYNC_STAT, 32'h0);
      rd_chk("irq enable", IDX_IRQ_EN, 32'h0);
      rd_chk("wrap limit", IDX_LIMIT, {16'h0, LIMIT_RST});
      axi_rd(6'h06, rd, rs);
      check("hole rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      axi_wr(6'h06, 16'h00FF, rs);
      check("hole bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
   endtask

   task automatic s_busy;
      logic [5:0] idx [4] = '{IDX_LIMIT, IDX_MATCH, IDX_COUNT, IDX_MAIN_CTRL};
      logic [15:0] val [4] = '{16'h0003, 16'h0002, 16'h0000, 16'h0000};
      int bitn [4] = '{B_LIM, B_MATCH, B_CNT, B_MAIN};
      for (int i = 0; i < 4; i++) begin
         wr(idx[i], val[i]);
         rd_chk("busy bit", IDX_SYNC_STAT, 32'h1 << bitn[i]);
         wait_idle();
      end
      rd_chk("wrap limit", IDX_LIMIT, 32'h3);
   endtask

   // Limit 3, match 2: one lap gives both flags
   task automatic s_irq;
      wr(IDX_IRQ_EN, 16'h0001);
      wr(IDX_MAIN_CTRL, 16'h0001);
      wait_idle();
      wait_sig(counter_irq, "counter irq");
      rd_chk("counter flags", IDX_IRQ_FLAGS, 32'h3);
      pulse(wrap_ev, "wrap event");
      pulse(match_ev, "match event");
      wr(IDX_IRQ_EN, 16'h0000);
      see("irq masked", counter_irq, 1'b0);
      wr(IDX_IRQ_EN, 16'h0002);
      see("match irq", counter_irq, 1'b1);
      wr(IDX_LIMIT, 16'hFFFF);
      wait_idle();
   endtask

   task automatic s_sleep;
      cpu_halted_in <= 1'b1;
      moved(1'b0);
      wr(IDX_DBG_CTRL, 16'h0001);
      moved(1'b1);
      wr(IDX_DBG_CTRL, 16'h0000);
      cpu_halted_in <= 1'b0;
      sleep_standby_in <= 1'b1;
      moved(1'b0);
      wr(IDX_MAIN_CTRL, 16'h0081);
      wait_idle();
      moved(1'b1);
      sleep_standby_in <= 1'b0;
   endtask

   // 400 bus cycles hold 40 slow edges
   task automatic s_divider;
      int dl;
      int e;
      for (int dv = 0; dv < 3; dv += 2) begin
         wr(IDX_MAIN_CTRL, 16'(1 + (dv << MC_DIV_LSB)));
         wait_idle();
         delta(400, dl);
         e = 40 >> dv;
         check("steps", 32'h1, {31'h0, dl >= e - 1 && dl <= e + 1});
      end
   endtask

   task automatic s_tick;
      int hi;
      hi = 0;
      wr(IDX_TICK_EN, 16'h0001);
      sleep_standby_in <= 1'b1;
      wr(IDX_TICK_CTRL, 16'h0009);
      rd_chk("tick busy", IDX_TICK_STAT, 32'h1);
      wait_idle();
      wait_sig(tick_irq, "tick irq");
      rd_chk("tick flag", IDX_TICK_FLAGS, 32'h1);
      cpu_halted_in <= 1'b1;
      repeat (10) @(posedge ref_clk_in);
      for (int i = 0; i < 100; i++) begin
         @(negedge ref_clk_in);
         hi += (tick_level === 1'b1);
      end
      @(posedge ref_clk_in);
      check("tick high in halt", 32'h0, 32'(hi));
      cpu_halted_in <= 1'b0;
      sleep_standby_in <= 1'b0;
      wr(IDX_TICK_CTRL, 16'h0000);
      wait_idle();
      wr(IDX_TICK_FLAGS, 16'h0001);
      rd_chk("tick flag clear", IDX_TICK_FLAGS, 32'h0);
      see("tick irq", tick_irq, 1'b0);
   endtask

   task automatic s_clear;
      wr(IDX_MAIN_CTRL, 16'h0000);
      wait_idle();
      moved(1'b0);
      rd_chk("flags", IDX_IRQ_FLAGS, 32'h3);
      wr(IDX_IRQ_FLAGS, 16'h0000);
      rd_chk("flags kept", IDX_IRQ_FLAGS, 32'h3);
      wr(IDX_IRQ_FLAGS, 16'h0001);
      rd_chk("wrap clear", IDX_IRQ_FLAGS, 32'h2);
      see("irq on match", counter_irq, 1'b1);
      wr(IDX_IRQ_FLAGS, 16'h0002);
      rd_chk("match clear", IDX_IRQ_FLAGS, 32'h0);
      see("irq cleared", counter_irq, 1'b0);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      repeat (4) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      s_reset();
      s_busy();
      s_irq();
      s_sleep();
      s_divider();
      s_tick();
      s_clear();
      stop_test();
   end
endmodule
